//--- mra_map.svh
`ifndef MRA_MAP_SVH
`define MRA_MAP_SVH
// Bus widths and burst length
`define MRA_CA_WIDTH        10
`define MRA_DQ_WIDTH        32
`define MRA_LANES           4
`define MRA_BURST_BEATS     8
`define MRA_BEAT_WIDTH      3
// Mode register numbers
`define MRA_TEMP_REG        8'h04
`define MRA_CAL_A_REG       8'h20
`define MRA_CAL_B_REG       8'h28
// Calibration patterns, bit n is beat n
`define MRA_CAL_A_PATTERN   8'h55
`define MRA_CAL_B_PATTERN   8'hcc
// Timing
`define MRA_READ_LATENCY    8'h0c
`define MRA_WRITE_PERIOD    8'h0a
`define MRA_TSI_MS          32
`define MRA_CLK_MHZ         100
`define MRA_TSI_CYCLES      (`MRA_TSI_MS * 1000 * `MRA_CLK_MHZ)
`endif

//--- mra_pkg.sv
package mra_pkg;
  typedef enum logic [3:0] {
    MRA_IDLE  = 4'b0001,
    MRA_WAIT  = 4'b0010,
    MRA_BURST = 4'b0100,
    MRA_WRITE = 4'b1000
  } mra_state_type;
  typedef enum logic [1:0] {
    MRA_SRC_REG  = 2'h0,
    MRA_SRC_CALA = 2'h1,
    MRA_SRC_CALB = 2'h2
  } mra_src_type;
endpackage : mra_pkg

//--- mra_top.sv
`timescale 1ns/100ps
`include "mra_map.svh"

// Contract
// RULE1: Read is chip select low, CA2..0 low, CA3 high on rising edge.
// RULE2: Read answers with eight beats, all strobes toggling for the burst.
// RULE3: Controller issues only no-ops during the read period.
// RULE4: Register value on DQ7..0 beat 0; other beats and lines undefined.
// RULE5: Controller waits the read-to-write spacing after a read.
// RULE6: Controller waits the read-to-register-write spacing after a read.
// RULE7: Controller waits half a burst after a read before register read.
// RULE8: Controller waits the write-to-read spacing before register read.
// RULE9: Controller waits row-to-column delay after power-down exit before reads.
// RULE10: Temperature status sits in register 4, bits 2..0, read normally.
// RULE11: Temperature status refreshed internally at most 32 ms apart; the block waits past TSI_CYCLES while the sensor code changes.
// RULE12: Controller polls temperature often enough to stay within 2 degrees.
// RULE13: Register 32 gives pattern A, register 40 pattern B, on lane line 0.
// RULE14: Calibration reads copy each lane's line 0 onto its other lines.
// RULE15: Pattern A beats 0..6 are 1,0,1,0,1,0,1.
// RULE16: Pattern B beats 0..6 are 0,0,1,1,0,0,1.
// RULE17: Beat 7 is 0 for pattern A and 1 for pattern B.
// RULE18: Controller issues calibration reads only while idle.
// RULE19: Write is CA3..0 low; address from fall 1..0, rise 9..4; data fall 9..2.
// RULE20: Register write holds the write period, then the block is idle.
// RULE21: Writes to read-only registers are ignored.
// RULE22: Controller issues register writes only with all banks precharged; the test issues one with banks_active high to check the refusal.
// RULE23: Reads allowed with banks active; writes not.
module mra_top
  import mra_pkg::*;
#(
  parameter int TSI_CYCLES = `MRA_TSI_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  input  wire logic                       cs_n,
  input  wire logic [`MRA_CA_WIDTH-1:0]   ca_rise,
  input  wire logic [`MRA_CA_WIDTH-1:0]   ca_fall,
  input  wire logic [2:0]                 temp_sense,
  input  wire logic                       banks_active,
  output logic      [`MRA_DQ_WIDTH-1:0]   dq_out,
  output logic                            dq_oe,
  output logic      [`MRA_LANES-1:0]      dqs_out,
  output logic                            dqs_oe,
  output logic                            busy,
  output logic      [7:0]                 last_write_reg,
  output logic      [7:0]                 last_write_data,
  output logic                            write_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic                     cs_n_s1, cs_n_s2;
  logic [`MRA_CA_WIDTH-1:0] car_s1, car_s2, caf_s1, caf_s2;
  logic [2:0]               temp_s1, temp_s2;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      car_s1  <= '0;
      car_s2  <= '0;
      caf_s1  <= '0;
      caf_s2  <= '0;
      temp_s1 <= 3'h0;
      temp_s2 <= 3'h0;
    end else if (clk_en) begin
      cs_n_s1 <= cs_n;
      cs_n_s2 <= cs_n_s1;
      car_s1  <= ca_rise;
      car_s2  <= car_s1;
      caf_s1  <= ca_fall;
      caf_s2  <= caf_s1;
      temp_s1 <= temp_sense;
      temp_s2 <= temp_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic [7:0] reg_addr(input logic [9:0] r, input logic [9:0] f);
    reg_addr = {r[9:4], f[1:0]};
  endfunction : reg_addr

  function automatic logic is_writable(input logic [7:0] a);
    // Status and calibration registers are read only
    is_writable = (a != `MRA_TEMP_REG) && (a != `MRA_CAL_A_REG) && (a != `MRA_CAL_B_REG);
  endfunction : is_writable

  logic       rd_cmd, wr_cmd;
  logic [7:0] cmd_addr;
  assign rd_cmd   = !cs_n_s2 && (car_s2[3:0] == 4'b1000); // [RULE1] [RULE23]
  assign wr_cmd   = !cs_n_s2 && (car_s2[3:0] == 4'b0000) && !banks_active; // [RULE19] [RULE23]
  assign cmd_addr = reg_addr(car_s2, caf_s2); // [RULE19]

  ////////////////////////////////////////////////////////////////////////////
  // Temperature snapshot, refreshed once every TSI_CYCLES, later while the sensor code is changing
  logic [31:0] tsi_cnt, next_tsi_cnt;
  logic [2:0]  temp_stat, next_temp_stat;
  logic [2:0]  temp_s3;

  // Multi-bit code kept only when steady for two samples, so a torn
  // value never lands; a changing code delays the update until it holds steady
  always_comb begin
    next_tsi_cnt   = tsi_cnt + 32'h1;
    next_temp_stat = temp_stat;
    if (tsi_cnt >= 32'(TSI_CYCLES - 1)) begin
      if (temp_s2 == temp_s3) begin
        next_tsi_cnt   = 32'h0;
        next_temp_stat = temp_s2; // [RULE11]
      end else begin
        next_tsi_cnt   = tsi_cnt;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tsi_cnt   <= 32'h0;
      temp_stat <= 3'h0;
      temp_s3   <= 3'h0;
    end else if (clk_en) begin
      tsi_cnt   <= next_tsi_cnt;
      temp_stat <= next_temp_stat;
      temp_s3   <= temp_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command state machine and register store
  mra_state_type state, next_state;
  mra_src_type   src, next_src;
  logic [7:0]    cnt, next_cnt;
  logic [7:0]    rd_val, next_rd_val;
  logic [`MRA_BEAT_WIDTH-1:0] beat, next_beat;
  logic [7:0]    mreg [0:255];
  logic [7:0]    next_lwr, next_lwd;
  logic          next_wstb;

  always_comb begin
    next_state  = state;
    next_src    = src;
    next_cnt    = cnt;
    next_rd_val = rd_val;
    next_beat   = beat;
    next_lwr    = last_write_reg;
    next_lwd    = last_write_data;
    next_wstb   = 1'b0;
    case (state)
      MRA_IDLE: begin
        if (rd_cmd) begin
          next_state = MRA_WAIT;
          next_cnt   = `MRA_READ_LATENCY - 8'h1;
          next_beat  = '0;
          if (cmd_addr == `MRA_CAL_A_REG) begin
            next_src = MRA_SRC_CALA; // [RULE13]
          end else if (cmd_addr == `MRA_CAL_B_REG) begin
            next_src = MRA_SRC_CALB; // [RULE13]
          end else begin
            next_src = MRA_SRC_REG;
          end
          if (cmd_addr == `MRA_TEMP_REG) begin
            next_rd_val = {5'h00, temp_stat}; // [RULE10]
          end else begin
            next_rd_val = mreg[cmd_addr];
          end
        end else if (wr_cmd) begin
          next_state = MRA_WRITE;
          next_cnt   = `MRA_WRITE_PERIOD - 8'h1;
          if (is_writable(cmd_addr)) begin // [RULE21]
            next_lwr  = cmd_addr;
            next_lwd  = caf_s2[9:2]; // [RULE19]
            next_wstb = 1'b1;
          end
        end
      end
      MRA_WAIT: begin
        next_cnt = cnt - 8'h1;
        if (cnt == 8'h0) begin
          next_state = MRA_BURST;
        end
      end
      MRA_BURST: begin
        next_beat = beat + 3'h1;
        if (beat == 3'(`MRA_BURST_BEATS - 1)) begin // [RULE2]
          next_state = MRA_IDLE;
        end
      end
      MRA_WRITE: begin
        next_cnt = cnt - 8'h1;
        if (cnt == 8'h0) begin
          next_state = MRA_IDLE; // [RULE20]
        end
      end
      default: begin
        next_state = MRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state           <= MRA_IDLE;
      src             <= MRA_SRC_REG;
      cnt             <= 8'h0;
      rd_val          <= 8'h0;
      beat            <= '0;
      last_write_reg  <= 8'h0;
      last_write_data <= 8'h0;
      write_strobe    <= 1'b0;
    end else if (clk_en) begin
      state           <= next_state;
      src             <= next_src;
      cnt             <= next_cnt;
      rd_val          <= next_rd_val;
      beat            <= next_beat;
      last_write_reg  <= next_lwr;
      last_write_data <= next_lwd;
      write_strobe    <= next_wstb;
    end
  end

  // Store written values; contents undefined until first write
  always_ff @(posedge mclk) begin
    if (!rst && clk_en && next_wstb) begin
      mreg[next_lwr] <= next_lwd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data, registered one beat ahead of the pins
  logic [`MRA_DQ_WIDTH-1:0] next_dq;
  logic                     next_oe;
  logic [`MRA_LANES-1:0]    next_dqs;
  logic                     cal_bit;

  always_comb begin
    next_dq  = '0;
    next_oe  = (state == MRA_BURST);
    next_dqs = '0;
    cal_bit  = 1'b0;
    if (state == MRA_BURST) begin
      next_dqs = {`MRA_LANES{beat[0]}}; // [RULE2]
      case (src)
        MRA_SRC_CALA: cal_bit = 1'(`MRA_CAL_A_PATTERN >> beat); // [RULE15] [RULE17]
        MRA_SRC_CALB: cal_bit = 1'(`MRA_CAL_B_PATTERN >> beat); // [RULE16] [RULE17]
        default:      cal_bit = 1'b0;
      endcase
      if (src == MRA_SRC_REG) begin
        // Undefined beats and lanes are driven low for simplicity
        next_dq = (beat == 3'h0) ? {24'h000000, rd_val} : '0; // [RULE4]
      end else begin
        next_dq = {`MRA_DQ_WIDTH{cal_bit}}; // [RULE14]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dq_out  <= '0;
      dq_oe   <= 1'b0;
      dqs_out <= '0;
      dqs_oe  <= 1'b0;
    end else if (clk_en) begin
      dq_out  <= next_dq;
      dq_oe   <= next_oe;
      dqs_out <= next_dqs;
      dqs_oe  <= next_oe;
    end
  end

  assign busy = (state != MRA_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Burst beat counter for the checks; frozen with the rest of the block
  logic [3:0] oe_run, next_oe_run;

  always_comb begin
    next_oe_run = dq_oe ? oe_run + 4'h1 : 4'h0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      oe_run <= 4'h0;
    end else if (clk_en) begin
      oe_run <= next_oe_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_burst_length: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
    $fell(dq_oe) |-> oe_run == 4'h8)
    else $error("read burst not eight beats");
  chk_burst_strobes: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
    dq_oe |-> (dqs_oe && oe_run < 4'h8))
    else $error("strobes not driven for the burst");
  chk_freeze_hold: assert property (@(posedge mclk) disable iff (rst)
    (!clk_en && !rst) |=> ($stable(dq_out) && $stable(dq_oe) && $stable(busy)))
    else $error("outputs moved while clock enable low");
  chk_write_period: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
    (clk_en && state == MRA_WRITE && cnt == 8'h0) |=> !busy)
    else $error("write period did not end idle");
  chk_cal_a_beat0: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
    (state == MRA_BURST && src == MRA_SRC_CALA && beat == 3'h0 && clk_en)
      |=> dq_out == 32'hffffffff)
    else $error("pattern A beat 0 wrong");
  chk_cal_b_beat1: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
    (state == MRA_BURST && src == MRA_SRC_CALB && beat == 3'h1 && clk_en)
      |=> dq_out == 32'h00000000)
    else $error("pattern B beat 1 wrong");
  chk_cal_beat7: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
    (state == MRA_BURST && src == MRA_SRC_CALB && beat == 3'h7 && clk_en)
      |=> dq_out == 32'hffffffff)
    else $error("pattern B beat 7 wrong");
  chk_reg_upper_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
    (dq_oe && src == MRA_SRC_REG) |-> dq_out[31:8] == 24'h0)
    else $error("upper lines not quiet");
  chk_ro_ignored: assert property (@(posedge mclk) disable iff (rst) // [RULE21]
    write_strobe |-> is_writable(last_write_reg))
    else $error("read-only register written");
  chk_write_idle: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
    (clk_en && state == MRA_IDLE && wr_cmd) |=> busy)
    else $error("write period not entered");
  chk_read_start: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
    (clk_en && state == MRA_IDLE && rd_cmd) |=> state == MRA_WAIT)
    else $error("read not recognised");
  chk_write_banks: assert property (@(posedge mclk) disable iff (rst) // [RULE23]
    (clk_en && state == MRA_IDLE && banks_active) |=> !write_strobe)
    else $error("write with banks active");

endmodule : mra_top

//--- mra_ctrl_model.sv
`timescale 1ns/100ps
`include "mra_map.svh"
// Controller side of the command bus
module mra_ctrl_model (
  input  wire logic                     mclk,
  input  wire logic                     busy,
  output logic                          cs_n,
  output logic [`MRA_CA_WIDTH-1:0]      ca_rise,
  output logic [`MRA_CA_WIDTH-1:0]      ca_fall
);
  // Never enters power-down, so no exit spacing arises
  initial begin
    cs_n    = 1'b1;
    ca_rise = 10'h3ff;
    ca_fall = 10'h000;
  end
  ////////////////////////////////////////////////////////////////////////
  // Only no-ops while busy; four quiet cycles cover the input sync lag
  task wait_quiet();
    int q;
    q = 0;
    while (q < 4) begin
      @(negedge mclk);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
  endtask : wait_quiet
  // One command beat, then deselect and scramble the lines
  task issue(input logic [3:0] op, input logic [7:0] addr, input logic [7:0] data);
    wait_quiet();
    cs_n    = 1'b0;
    ca_rise = {addr[7:2], op};
    ca_fall = {data, addr[1:0]};
    @(negedge mclk);
    cs_n    = 1'b1;
    ca_rise = ~ca_rise; // Stale command must not look valid
    ca_fall = ~ca_fall;
  endtask : issue
endmodule : mra_ctrl_model

//--- mra_top_tb.sv
`timescale 1ns/100ps
`include "mra_map.svh"
module mra_top_tb;
  localparam int TSI = 16;
  logic        mclk, rst, clk_en, cs_n, banks_active;
  logic        dq_oe, dqs_oe, busy, write_strobe;
  logic [9:0]  ca_rise, ca_fall;
  logic [2:0]  temp_sense;
  logic [31:0] dq_out;
  logic [3:0]  dqs_out;
  logic [7:0]  last_write_reg, last_write_data;
  int          err_total, checked;
  ////////////////////////////////////////////////////////////////////////
  mra_top #(.TSI_CYCLES(TSI)) u_mra_top (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall), .temp_sense(temp_sense),
    .banks_active(banks_active), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .busy(busy), .last_write_reg(last_write_reg),
    .last_write_data(last_write_data), .write_strobe(write_strobe));
  mra_ctrl_model u_mra_ctrl_model (.mclk(mclk), .busy(busy), .cs_n(cs_n),
    .ca_rise(ca_rise), .ca_fall(ca_fall));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Read one register and walk the whole burst
  task rd(input logic [7:0] addr, input logic [7:0] exp, input bit cal);
    int n;
    u_mra_ctrl_model.issue(4'h8, addr, 8'h00);
    n = 0;
    while (dq_oe !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("burst start", 32'h1, {31'h0, dq_oe});
    for (n = 0; n < 8; n++) begin
      chk("strobes", {28'h0, {4{n[0]}}}, {28'h0, dqs_out});
      chk("strobe enable", 32'h1, {31'h0, dqs_oe});
      if (cal) chk("cal beat", {32{exp[n]}}, dq_out);
      else if (n == 0) chk("reg byte", {24'h0, exp}, {24'h0, dq_out[7:0]});
      @(negedge mclk);
    end
    chk("burst end", 32'h0, {31'h0, dq_oe});
  endtask : rd
  // Write and watch strobe, stored fields and the busy span
  task wr(input logic [7:0] addr, input logic [7:0] data, input bit take, input int span);
    logic [7:0] old_reg, old_data;
    int         n, hi;
    bit         seen;
    old_reg  = last_write_reg;
    old_data = last_write_data;
    seen     = 0;
    hi       = 0;
    u_mra_ctrl_model.issue(4'h0, addr, data);
    for (n = 0; n < 30; n++) begin
      @(negedge mclk);
      if (write_strobe === 1'b1) seen = 1;
      if (busy === 1'b1) hi++;
    end
    chk("write strobe", {31'h0, take}, {31'h0, seen});
    chk("write reg", {24'h0, take ? addr : old_reg}, {24'h0, last_write_reg});
    chk("write data", {24'h0, take ? data : old_data}, {24'h0, last_write_data});
    chk("write period", span, hi);
  endtask : wr
  task wrap_up();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  // Watchdog at 10000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    $display("Error watchdog expected finish seen timeout");
    wrap_up();
  end
  // Test sequence
  initial begin
    err_total    = 0;
    checked      = 0;
    rst          = 1'b1;
    clk_en       = 1'b1;
    temp_sense   = 3'h5;
    banks_active = 1'b0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk("reset outputs", 32'h0, {21'h0, dq_oe, busy, write_strobe, last_write_reg});
    rd(`MRA_CAL_A_REG, `MRA_CAL_A_PATTERN, 1);
    rd(`MRA_CAL_B_REG, `MRA_CAL_B_PATTERN, 1);
    repeat (TSI + 4) @(negedge mclk);
    rd(`MRA_TEMP_REG, 8'h05, 0);
    wr(8'h0a, 8'h5a, 1, 10);
    rd(8'h0a, 8'h5a, 0);
    wr(`MRA_TEMP_REG, 8'hff, 0, 10);
    wr(`MRA_CAL_A_REG, 8'h0f, 0, 10);
    wr(`MRA_CAL_B_REG, 8'hf0, 0, 10);
    // Open bank: writes refused, reads still served
    banks_active = 1'b1;
    temp_sense   = 3'h2;
    wr(8'h0b, 8'h33, 0, 0);
    repeat (TSI + 4) @(negedge mclk);
    rd(`MRA_TEMP_REG, 8'h02, 0);
    banks_active = 1'b0;
    wr(8'h0b, 8'h33, 1, 10);
    // Freeze mid burst: pattern B beat 2 holds, then the last five beats follow
    u_mra_ctrl_model.issue(4'h8, `MRA_CAL_B_REG, 8'h00);
    while (dq_oe !== 1'b1) @(negedge mclk);
    repeat (2) @(negedge mclk);
    clk_en = 1'b0;
    repeat (5) @(negedge mclk);
    chk("frozen beat", 32'hffffffff, dq_out);
    chk("frozen enable", 32'h1, {31'h0, dq_oe});
    clk_en = 1'b1;
    repeat (5) @(negedge mclk);
    chk("resumed burst", 32'h1, {31'h0, dq_oe});
    @(negedge mclk);
    chk("resumed end", 32'h0, {31'h0, dq_oe});
    wrap_up();
  end
endmodule : mra_top_tb
